// >>> rtl/fimr_regs.vh
// Purpose: constants for the interrupt message router
// Assumes: included once per compile unit via guard
// Notes: fixed apic windows and message field layout
`ifndef FIMR_REGS_VH
`define FIMR_REGS_VH
// fixed apic windows: base address bits [31:20] and port select field
`define FIMR_APIC_WIN_HI 12'hfec
`define FIMR_APIC_PORT_LSB 15
`define FIMR_APIC_PORT_W 2
// fallback assert register offset inside an apic window
`define FIMR_APIC_ASSERT_OFS 12'h020
// fsb interrupt address fields
`define FIMR_HINT_BIT 3
`define FIMR_DMODE_BIT 2
`define FIMR_DID_LSB 12
`define FIMR_DID_MSB 19
`define FIMR_DID_BCAST 8'hff
// message kinds on the inbound port
`define FIMR_K_MWR 2'h0
`define FIMR_K_INTX_AS 2'h1
`define FIMR_K_INTX_DE 2'h2
// top priority and reset bucket limits
`define FIMR_PRIO_TOP 5'h10
`define FIMR_RST_LIM0 4'h4
`define FIMR_RST_LIM1 4'h8
`define FIMR_RST_LIM2 4'hc
`endif

// >>> rtl/fimr_redirect.v
// Purpose: redirection winner pick over task priority entries
// Assumes: entries stable while o_done pending
// Notes: bucket sort then least recently used tie break
`include "fimr_regs.vh"
module fimr_redirect #(
	parameter N = 4
) (
	input wire i_clk_sys,
	input wire i_rst_n,
	input wire i_start,
	input wire i_phys,
	input wire [7:0] i_did,
	input wire [N-1:0] i_en,
	input wire [N*8-1:0] i_logid,
	input wire [N*4-1:0] i_prio,
	input wire [11:0] i_lims,
	output reg o_done,
	output reg o_hit,
	output reg [7:0] o_id
);
	// map a priority to its bucket 0..3
	function [1:0] bucket;
		input [3:0] p;
		input [11:0] l;
		begin
			if (p < l[3:0])
				bucket = 2'd0;
			else if (p < l[7:4])
				bucket = 2'd1;
			else if (p < l[11:8])
				bucket = 2'd2;
			else
				bucket = 2'd3;
		end
	endfunction
	wire [N-1:0] pool;
	wire [N*2-1:0] bk;
	reg [N-1:0] lru_r;
	reg [N-1:0] lru_nxt;
	genvar g;
	// pool membership and buckets per entry
	generate
		for (g = 0; g < N; g = g + 1)
		begin : g_ent
			assign pool[g] = i_en[g] & (i_phys | (|(i_did & i_logid[g*8+:8])));
			assign bk[g*2+:2] = bucket(i_prio[g*4+:4], i_lims);
		end
	endgenerate
	integer k;
	reg [1:0] best;
	reg found;
	reg [7:0] pick_id;
	reg [N-1:0] win;
	// [RL18] four bucket sort
	// [RL19] lowest bucket, lru tie
	always @*
	begin
		best = 2'd3;
		found = 1'b0;
		pick_id = i_did;
		win = {N{1'b0}};
		lru_nxt = lru_r;
		for (k = 0; k < N; k = k + 1)
			if (pool[k] && bk[k*2+:2] < best)
				best = bk[k*2+:2];
		// first pass prefers entries not recently picked
		for (k = 0; k < N; k = k + 1)
			if (!found && pool[k] && bk[k*2+:2] == best && !lru_r[k])
			begin
				found = 1'b1;
				win[k] = 1'b1;
				pick_id = i_phys ? k[7:0] : i_logid[k*8+:8];
			end
		for (k = 0; k < N; k = k + 1)
			if (!found && pool[k] && bk[k*2+:2] == best)
			begin
				found = 1'b1;
				win[k] = 1'b1;
				pick_id = i_phys ? k[7:0] : i_logid[k*8+:8];
			end
		if (found)
			lru_nxt = ((lru_r | win) == {N{1'b1}}) ? win : (lru_r | win);
	end
	// register the result one cycle after start
	always @(posedge i_clk_sys or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			o_done <= 1'b0;
			o_hit <= 1'b0;
			o_id <= 8'h00;
			lru_r <= {N{1'b0}};
		end
		else
		begin
			o_done <= i_start;
			if (i_start)
			begin
				o_hit <= found;
				o_id <= pick_id;
				lru_r <= lru_nxt;
			end
		end
	end
endmodule // fimr_redirect

// >>> rtl/fimr_router.v
// Purpose: route inbound interrupt writes and fsb interrupt messages
// Assumes: one core clock, inputs synchronous
// Notes: apic windows are fixed decode, not programmable
// Notes: one fsb request is handled at a time, from idle only
`include "fimr_regs.vh"
// Functional notes
// [RL1] device sends msi as one dword write
// [RL2] fallback writes apic base plus 20
// [RL3] apic window write goes to mapped port
// [RL4] apic windows hard-wired, not relocatable
// [RL5] fallback assert forwarded like plain write
// [RL6] interrupt message stays behind posted data
// [RL7] legacy intx assert/deassert messages supported
// [RL8] claim fsb interrupts, target ready, no data
// [RL9] fsb interrupts never deferred, in order
// [RL10] directed: complete and forward other bus
// [RL11] redirectable: reissue both buses, hint cleared
// [RL12] broadcast id all ones forwarded
// [RL13] no resources: hold priority request asserted
// [RL14] deferred access ends after post/data
// [RL15] read-for-ownership reply after invalidation
// [RL16] processor waits before ordered ipi
// [RL17] no ordering among ipis required
// [RL18] sort entries into four buckets
// [RL19] lowest bucket wins, lru tie break
// [RL20] accept stalled interrupt, then release request; the request is released one cycle before the claim
module fimr_router #(
	parameter N = 4,
	parameter PORTS = 4
) (
	input wire i_clk_sys,
	input wire i_rst_n,
	// inbound pci express writes and messages
	input wire i_in_valid,
	input wire [1:0] i_in_kind,
	input wire [31:0] i_in_addr,
	input wire [31:0] i_in_data,
	input wire i_in_posted_pend,
	output reg o_in_ready,
	// downstream port forward
	output reg o_dn_valid,
	output reg [1:0] o_dn_port,
	output reg [31:0] o_dn_addr,
	output reg [31:0] o_dn_data,
	// inbound interrupt to processor side
	output reg o_up_int_valid,
	output reg [31:0] o_up_int_addr,
	output reg [31:0] o_up_int_data,
	output reg [PORTS-1:0] o_intx_level,
	// front side bus interrupt requests
	input wire i_fsb_valid,
	input wire i_fsb_src,
	input wire [31:0] i_fsb_addr,
	input wire [31:0] i_fsb_data,
	input wire i_fsb_space,
	input wire i_fsb_rfo,
	input wire i_fsb_inval_done,
	input wire i_fsb_post_done,
	output reg o_target_ready_n,
	output reg o_no_data_resp,
	output reg o_defer,
	output reg o_defer_reply,
	output reg o_priority_bus_request_n,
	// reissued messages on each bus
	output reg [1:0] o_out_valid,
	output reg [31:0] o_out_addr,
	output reg [31:0] o_out_data,
	// task priority entries
	input wire [N-1:0] i_tpr_en,
	input wire [N*8-1:0] i_tpr_logid,
	input wire [N*4-1:0] i_tpr_prio,
	input wire [11:0] i_bucket_lims
);
	// inbound decode, mode-free address compare
	// [RL4] fixed window decode
	function is_apic;
		input [31:0] a;
		begin
			is_apic = (a[31:20] == `FIMR_APIC_WIN_HI);
		end
	endfunction
	// inbound kind match, shared by the routing branches
	function kind_is;
		input [1:0] k;
		input [1:0] want;
		begin
			kind_is = (k == want);
		end
	endfunction
	wire in_apic = is_apic(i_in_addr);
	// [RL6] nothing taken while older posted data is pending
	// ready lags the pending flag by one edge, so gate here too
	wire in_take = i_in_valid & o_in_ready & ~i_in_posted_pend;
	wire in_mwr = in_take & kind_is(i_in_kind, `FIMR_K_MWR);
	wire in_as = in_take & kind_is(i_in_kind, `FIMR_K_INTX_AS);
	wire in_de = in_take & kind_is(i_in_kind, `FIMR_K_INTX_DE);
	// accept inbound when no posted data ahead
	// [RL6] wait for posted data
	always @(posedge i_clk_sys or negedge i_rst_n)
	begin
		if (!i_rst_n)
			o_in_ready <= 1'b0;
		else
			o_in_ready <= ~i_in_posted_pend;
	end
	// route writes and intx messages
	always @(posedge i_clk_sys or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			o_dn_valid <= 1'b0;
			o_dn_port <= 2'h0;
			o_dn_addr <= 32'h0000_0000;
			o_dn_data <= 32'h0000_0000;
			o_up_int_valid <= 1'b0;
			o_up_int_addr <= 32'h0000_0000;
			o_up_int_data <= 32'h0000_0000;
			o_intx_level <= {PORTS{1'b0}};
		end
		else
		begin
			o_dn_valid <= 1'b0;
			o_up_int_valid <= 1'b0;
			if (in_mwr)
			begin
				if (in_apic)
				begin
					// [RL3] mapped port select
					// [RL5] fallback forwarded unchanged
					o_dn_valid <= 1'b1;
					o_dn_port <= i_in_addr[`FIMR_APIC_PORT_LSB+:`FIMR_APIC_PORT_W];
					o_dn_addr <= i_in_addr;
					o_dn_data <= i_in_data;
				end
				else
				begin
					o_up_int_valid <= 1'b1;
					o_up_int_addr <= i_in_addr;
					o_up_int_data <= i_in_data;
				end
			end
			// [RL7] intx level tracking
			if (in_as)
				o_intx_level[i_in_data[1:0]] <= 1'b1;
			if (in_de)
				o_intx_level[i_in_data[1:0]] <= 1'b0;
		end
	end
	// fsb interrupt handling state machine
	localparam S_IDLE = 3'd0;
	localparam S_STALL = 3'd1;
	localparam S_CLAIM = 3'd2;
	localparam S_REDIR = 3'd3;
	localparam S_ISSUE = 3'd4;
	localparam S_DEFER = 3'd5;
	// state and the captured bus request
	reg [2:0] st_r;
	reg [2:0] st_nxt;
	reg busy_r;
	reg [31:0] addr_r;
	reg [31:0] data_r;
	reg src_r;
	reg rfo_r;
	// redirection unit results
	wire red_done;
	wire red_hit;
	wire [7:0] red_id;
	// a request is only seen while the machine is idle
	wire fsb_take = (st_r == S_IDLE) & i_fsb_valid;
	// winner pick runs for one cycle in the redirect state
	wire redir_go = (st_r == S_REDIR);
	// the new message: winner id, hint bit forced low
	wire [31:0] redir_addr = {addr_r[31:20],
		red_hit ? red_id : addr_r[19:12],
		addr_r[11:4], 1'b0, addr_r[2:0]};
	// defer ends on invalidation for rfo, else on posting
	wire defer_end = rfo_r ? i_fsb_inval_done : i_fsb_post_done;
	// winner pick for redirectable interrupts
	fimr_redirect #(
		.N(N)
	) u_redir (
		.i_clk_sys(i_clk_sys),
		.i_rst_n(i_rst_n),
		.i_start(redir_go),
		.i_phys(~addr_r[`FIMR_DMODE_BIT]),
		.i_did(addr_r[`FIMR_DID_MSB:`FIMR_DID_LSB]),
		.i_en(i_tpr_en),
		.i_logid(i_tpr_logid),
		.i_prio(i_tpr_prio),
		.i_lims(i_bucket_lims),
		.o_done(red_done),
		.o_hit(red_hit),
		.o_id(red_id)
	);
	// next state
	always @*
	begin
		st_nxt = st_r;
		case (st_r)
			S_IDLE:
				if (i_fsb_valid && i_fsb_space)
					st_nxt = busy_r ? S_STALL : S_CLAIM;
				else if (i_fsb_valid)
					st_nxt = S_DEFER;
			// [RL20] accept when free
			S_STALL:
				if (!busy_r)
					st_nxt = S_CLAIM;
			S_CLAIM:
				st_nxt = addr_r[`FIMR_HINT_BIT] ? S_REDIR : S_ISSUE;
			S_REDIR:
				st_nxt = S_IDLE;
			S_ISSUE:
				st_nxt = S_IDLE;
			// [RL14] hold until posted
			// [RL15] hold rfo until invalidated
			S_DEFER:
				if (defer_end)
					st_nxt = S_IDLE;
			default:
				st_nxt = S_IDLE;
		endcase
	end
	// state and request capture
	always @(posedge i_clk_sys or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			st_r <= S_IDLE;
			addr_r <= 32'h0000_0000;
			data_r <= 32'h0000_0000;
			src_r <= 1'b0;
			rfo_r <= 1'b0;
			busy_r <= 1'b0;
		end
		else
		begin
			st_r <= st_nxt;
			// outbound slot busy while redirection resolves
			busy_r <= (st_nxt == S_REDIR) | redir_go;
			if (fsb_take)
			begin
				addr_r <= i_fsb_addr;
				data_r <= i_fsb_data;
				src_r <= i_fsb_src;
				rfo_r <= i_fsb_rfo;
			end
		end
	end
	// bus responses: claim, defer and priority request
	always @(posedge i_clk_sys or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			o_target_ready_n <= 1'b1;
			o_no_data_resp <= 1'b0;
			o_defer <= 1'b0;
			o_defer_reply <= 1'b0;
			o_priority_bus_request_n <= 1'b1;
		end
		else
		begin
			// [RL8] claim with no data
			// [RL9] completed in order
			// [RL17] no ipi ordering kept
			o_target_ready_n <= ~(st_r == S_CLAIM);
			o_no_data_resp <= (st_r == S_CLAIM);
			// [RL14] only accesses outside interrupt space are deferred
			o_defer <= fsb_take & ~i_fsb_space;
			// [RL15] reply once the done input is seen
			o_defer_reply <= (st_r == S_DEFER) & defer_end;
			// [RL13] hold request while stalled
			o_priority_bus_request_n <= ~(st_nxt == S_STALL);
		end
	end
	// reissued and forwarded messages, one-cycle pulses
	always @(posedge i_clk_sys or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			o_out_valid <= 2'b00;
			o_out_addr <= 32'h0000_0000;
			o_out_data <= 32'h0000_0000;
		end
		else
		begin
			o_out_valid <= 2'b00;
			if (st_r == S_ISSUE)
			begin
				// [RL10] forward directed to other bus
				// [RL12] broadcast forwarded too
				o_out_valid <= src_r ? 2'b01 : 2'b10;
				o_out_addr <= addr_r;
				o_out_data <= data_r;
			end
			if (red_done)
			begin
				// [RL11] both buses, hint cleared
				o_out_valid <= 2'b11;
				o_out_addr <= redir_addr;
				o_out_data <= data_r;
			end
		end
	end
endmodule // fimr_router

// >>> sim/fimr_router_assertions.sv
// Purpose: port timing checks for the interrupt router
// Assumes: one clock, async low reset
// Notes: answer latencies allowed a short window
module fimr_router_chk (
	input wire i_clk_sys,
	input wire i_rst_n,
	input wire i_in_valid,
	input wire [1:0] i_in_kind,
	input wire [31:0] i_in_addr,
	input wire i_in_posted_pend,
	input wire o_in_ready,
	input wire o_dn_valid,
	input wire [1:0] o_dn_port,
	input wire [31:0] o_dn_addr,
	input wire i_fsb_valid,
	input wire i_fsb_space,
	input wire i_fsb_inval_done,
	input wire i_fsb_post_done,
	input wire o_target_ready_n,
	input wire o_no_data_resp,
	input wire o_defer,
	input wire o_defer_reply,
	input wire o_priority_bus_request_n,
	input wire [1:0] o_out_valid,
	input wire [31:0] o_out_addr
);
	default clocking cb @(posedge i_clk_sys); endclocking
	default disable iff (!i_rst_n);
	// plain memory write taken this edge
	wire take = i_in_valid && o_in_ready && !i_in_posted_pend &&
		i_in_kind == 2'h0;
	claim_resp_a: assert property (
		!o_target_ready_n |-> o_no_data_resp) else $error("bare claim");
	no_defer_a: assert property (
		i_fsb_valid && i_fsb_space |=> !o_defer [*4])
		else $error("interrupt deferred");
	fwd_apic_a: assert property (
		take && i_in_addr[31:20] == 12'hfec |-> ##[1:2] o_dn_valid)
		else $error("window write not forwarded");
	dn_port_a: assert property (
		o_dn_valid |-> o_dn_port == o_dn_addr[16:15])
		else $error("wrong port");
	post_hold_a: assert property (
		i_in_posted_pend && $past(i_in_posted_pend) |-> !o_in_ready)
		else $error("passed posted data");
	fwd_order_a: assert property (
		o_dn_valid |-> !$past(i_in_posted_pend))
		else $error("forward overtook posted data");
	stall_req_a: assert property (
		!o_priority_bus_request_n |=> o_priority_bus_request_n
		##1 !o_target_ready_n) else $error("stalled interrupt not taken");
	hint_clr_a: assert property (
		o_out_valid == 2'h3 |-> !o_out_addr[3]) else $error("hint set");
	claim_first_a: assert property (
		o_out_valid != 2'h0 |-> !$past(o_target_ready_n) ||
		!$past(o_target_ready_n, 2)) else $error("forward unclaimed");
	reply_cause_a: assert property (
		o_defer_reply |-> $past(i_fsb_inval_done) || $past(i_fsb_post_done))
		else $error("early reply");
	cover property (o_dn_valid);
	cover property (o_out_valid == 2'h3);
	cover property (o_defer_reply);
	cover property (!o_priority_bus_request_n);
endmodule // fimr_router_chk

bind fimr_router fimr_router_chk u_chk (.i_clk_sys, .i_rst_n,
	.i_in_valid, .i_in_kind, .i_in_addr, .i_in_posted_pend, .o_in_ready,
	.o_dn_valid, .o_dn_port, .o_dn_addr, .i_fsb_valid, .i_fsb_space,
	.i_fsb_inval_done, .i_fsb_post_done, .o_target_ready_n,
	.o_no_data_resp, .o_defer, .o_defer_reply, .o_priority_bus_request_n,
	.o_out_valid, .o_out_addr);

// >>> sim/fimr_fsb_agent.sv
// Purpose: processor bus agent issuing requests
// Assumes: drives on the falling edge
// Notes: released address and data lines show inverted values
module fimr_fsb_agent (
	input wire i_clk,
	output logic o_valid,
	output logic o_src,
	output logic [31:0] o_addr,
	output logic [31:0] o_data,
	output logic o_space,
	output logic o_rfo
);
	timeunit 1ns;
	timeprecision 1ns;
	// idle bus
	initial
	begin
		{o_valid, o_src, o_space, o_rfo} = 4'h0;
		{o_addr, o_data} = 64'h0;
	end
	task automatic req(input logic s, input logic [31:0] a,
		input logic sp, input logic r);
		@(negedge i_clk);
		{o_valid, o_src, o_space, o_rfo} = {1'b1, s, sp, r};
		o_addr = a;
		o_data = {a[15:0], a[31:16]};
		@(negedge i_clk);
		o_valid = 1'b0;
		o_addr = ~o_addr;
		o_data = ~o_data;
	endtask
endmodule // fimr_fsb_agent

// >>> sim/fsb_interrupt_message_router_bench.sv
// Purpose: directed tests of the interrupt router
// Assumes: 100 MHz clock, async low reset
// Notes: latencies found by bounded waits
module fsb_interrupt_message_router_bench;
	timeunit 1ns;
	timeprecision 1ns;
	logic i_clk_sys = 0, i_rst_n = 0, in_v = 0, pend = 0, inv_d = 0;
	logic post_d = 0, fv, fs, fsp, frfo, ir, dv, up, tr_n, ndr, df, dr;
	logic pr_n;
	logic [1:0] kind = 0, dp, ov;
	logic [3:0] lv;
	logic [31:0] ia = 0, id = 0, fa, fd, da, dd, oa, od, ua, ud;
	int fails = 0, check_count = 0, cyc = 0, n;
	// clock
	always #5 i_clk_sys = ~i_clk_sys;
	fimr_router #(.N(4), .PORTS(4)) u_fimr_router (.i_clk_sys, .i_rst_n,
		.i_in_valid(in_v), .i_in_kind(kind), .i_in_addr(ia),
		.i_in_data(id), .i_in_posted_pend(pend), .o_in_ready(ir),
		.o_dn_valid(dv), .o_dn_port(dp), .o_dn_addr(da), .o_dn_data(dd),
		.o_up_int_valid(up), .o_up_int_addr(ua), .o_up_int_data(ud),
		.o_intx_level(lv), .i_fsb_valid(fv), .i_fsb_src(fs),
		.i_fsb_addr(fa), .i_fsb_data(fd), .i_fsb_space(fsp),
		.i_fsb_rfo(frfo), .i_fsb_inval_done(inv_d),
		.i_fsb_post_done(post_d), .o_target_ready_n(tr_n),
		.o_no_data_resp(ndr), .o_defer(df), .o_defer_reply(dr),
		.o_priority_bus_request_n(pr_n), .o_out_valid(ov),
		.o_out_addr(oa), .o_out_data(od), .i_tpr_en(4'hf),
		.i_tpr_logid(32'h0804_0201), .i_tpr_prio(16'h729c),
		.i_bucket_lims(12'hc84));
	fimr_fsb_agent u_fimr_fsb_agent (.i_clk(i_clk_sys), .o_valid(fv),
		.o_src(fs), .o_addr(fa), .o_data(fd), .o_space(fsp), .o_rfo(frfo));
	// compare and report
	task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		check_count++;
		if (g !== e)
		begin
			fails++;
			$display("Error %s expected %h seen %h", nm, e, g);
		end
	endtask
	task stop_test;
		$display("checks %0d mismatches %0d", check_count, fails);
		if (fails == 0 && check_count > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	// hang guard
	always @(posedge i_clk_sys)
	begin
		cyc++;
		if (cyc == 3000)
		begin
			fails++;
			stop_test;
		end
	end
	// one inbound request, taken at the next rising edge
	task wr(input logic [1:0] k, input logic [31:0] a, input logic [31:0] d);
		@(negedge i_clk_sys);
		{in_v, kind, ia, id} = {1'b1, k, a, d};
		@(negedge i_clk_sys);
		in_v = 0;
	endtask
	task t_apic;
		wr(2'h0, 32'hfec0_8020, 32'h41);
		for (n = 0; n < 3 && !dv; n++)
			@(negedge i_clk_sys);
		chk("dn_port", 1, dp);
		chk("dn_addr", 32'hfec0_8020, da);
		chk("dn_data", 32'h41, dd);
		wr(2'h0, 32'hfee0_0000, 32'h42);
		for (n = 0; n < 3 && !up; n++)
			@(negedge i_clk_sys);
		chk("up_valid", 1, up);
		chk("up_addr", 32'hfee0_0000, ua);
		chk("up_data", 32'h42, ud);
		chk("dn_quiet", 0, dv);
		$display("test apic done");
	endtask
	task t_post;
		pend = 1;
		{in_v, kind, ia, id} = {1'b1, 2'h0, 32'hfec1_0020, 32'h51};
		@(negedge i_clk_sys);
		chk("no_fwd", 0, dv);
		repeat (2) @(negedge i_clk_sys);
		chk("ready_held", 0, ir);
		pend = 0;
		for (n = 0; n < 4 && !ir; n++)
			@(negedge i_clk_sys);
		@(negedge i_clk_sys);
		in_v = 0;
		for (n = 0; n < 3 && !dv; n++)
			@(negedge i_clk_sys);
		chk("late_port", 2, dp);
		$display("test posted done");
	endtask
	task t_intx;
		wr(2'h1, 32'h0, 32'h2);
		repeat (2) @(negedge i_clk_sys);
		chk("intx_set", 4'h4, lv);
		wr(2'h2, 32'h0, 32'h2);
		repeat (2) @(negedge i_clk_sys);
		chk("intx_clr", 0, lv);
		$display("test intx done");
	endtask
	task fsb_int(input logic s, input logic [31:0] a, input int lat,
		input logic [1:0] ev, input logic [31:0] ea);
		u_fimr_fsb_agent.req(s, a, 1'b1, 1'b0);
		for (n = 0; n < 4 && tr_n; n++)
			@(negedge i_clk_sys);
		chk("no_data", 1, ndr);
		chk("no_defer", 0, df);
		chk("prio_req", 1, pr_n);
		repeat (lat) @(negedge i_clk_sys);
		chk("out_valid", ev, ov);
		chk("out_addr", ea, oa);
		chk("out_data", {a[15:0], a[31:16]}, od);
	endtask
	// directed interrupt lands while the redirect result is pending
	task t_stall;
		u_fimr_fsb_agent.req(1'b0, 32'hfee0_1008, 1'b1, 1'b0);
		@(negedge i_clk_sys);
		u_fimr_fsb_agent.req(1'b1, 32'hfee0_3000, 1'b1, 1'b0);
		chk("stall_req", 0, pr_n);
		chk("redir_out", 2'h3, ov);
		for (n = 0; n < 4 && tr_n; n++)
			@(negedge i_clk_sys);
		chk("stall_claim", 0, tr_n);
		chk("stall_freed", 1, pr_n);
		@(negedge i_clk_sys);
		chk("stall_out", 2'h1, ov);
		$display("test stall done");
	endtask
	task t_defer(input logic r);
		u_fimr_fsb_agent.req(1'b0, 32'h1000, 1'b0, r);
		for (n = 0; n < 3 && !df; n++)
			@(negedge i_clk_sys);
		chk("defer", 1, df);
		repeat (3) @(negedge i_clk_sys);
		chk("early_reply", 0, dr);
		{inv_d, post_d} = r ? 2'b10 : 2'b01;
		for (n = 0; n < 4 && !dr; n++)
			@(negedge i_clk_sys);
		chk("reply", 1, dr);
		{inv_d, post_d} = 2'b00;
		$display("test defer done");
	endtask
	// main sequence
	initial
	begin
		repeat (10) @(negedge i_clk_sys);
		i_rst_n = 1;
		repeat (2) @(negedge i_clk_sys);
		t_apic;
		t_post;
		t_intx;
		fsb_int(1'b0, 32'hfee0_5000, 1, 2'h2, 32'hfee0_5000);
		fsb_int(1'b1, 32'hfeef_f000, 1, 2'h1, 32'hfeef_f000);
		fsb_int(1'b0, 32'hfee0_1008, 2, 2'h3, 32'hfee0_2000);
		$display("test fsb done");
		t_stall;
		t_defer(1'b1);
		t_defer(1'b0);
		stop_test;
	end
endmodule // fsb_interrupt_message_router_bench
